// file: aspm_modem.sv
/*
  Modem partner: answers only a ringing call, hangs up slowly after DTR
  drops, sends characters on the receive line. Assumes the bench clock.
*/
`timescale 1ns/1ps
module aspm_modem #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk_sys_i,
  input  wire logic dtr_i,
  input  wire logic ring_i,
  input  wire logic carrier_i,
  input  wire logic cts_en_i,
  output logic      dsr_o,
  output logic      dcd_o,
  output logic      cts_o,
  output logic      rxd_o
);
  int hang_cnt = 0;
  initial begin
    dsr_o = 1'b0;
    rxd_o = 1'b1;
  end
  assign dcd_o = dsr_o & carrier_i;
  assign cts_o = dsr_o & cts_en_i;
  always @(posedge clk_sys_i) begin
    // off-hook only on a ring with DTR
    if (dtr_i && ring_i) begin
      dsr_o <= 1'b1;
    end
    // hang-up takes a while, then DSR off
    if (dtr_i || !dsr_o) begin
      hang_cnt <= 0;
    end else if (hang_cnt == 12) begin
      dsr_o <= 1'b0;
    end else begin
      hang_cnt <= hang_cnt + 1;
    end
  end
  task automatic send_char(input logic [7:0] b, input logic par);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    // start, LSB first, even parity, one stop
    for (int i = 0; i < (par ? 11 : 10); i++) begin
      rxd_o <= (!par && i == 9) ? 1'b1 : f[i];
      repeat (BIT_CYC) @(posedge clk_sys_i);
    end
  endtask
endmodule

// file: aspm_pkg.sv
/*
  Shared constants for the asynchronous port block: timing, register map,
  field positions, framing and modem handshake states.
  Assumes a single 10 MHz system clock.
*/
// Operation
// [R1] Hold DTR on while waiting for calls
// [R2] Ignore ring indicator; detect calls by DSR
// [R3] DSR on starts ten-second carrier wait
// [R4] Carrier seen in time means connected
// [R5] No carrier in time drops DTR
// [R6] DSR off after hang-up restores DTR
// [R7] Carrier loss while connected restarts timeout
// [R8] Carrier still lost at timeout drops DTR
// [R9] Modem answers ringing call, raises DSR
// [R10] Modem hangs up, then drops DSR
// [R11] Modem never answers on DTR alone
// [R12] Start bit, eight data bits LSB first
// [R13] Optional even parity, then one stop
// [R14] Transmit light while master and sending
// [R15] Receive light while receiving a message
// [R16] Both lights while polling or soliciting
// [R17] Pending light while message waits unmastered
// [R18] Activity light on, blinks off per character
// [R19] Fault light half second per NAK
// [R20] Fault flashes 1 Hz duplicate, steady hardware
// [R21] RTS always full duplex, permit half duplex
// [R22] Transmit only while CTS on, pause otherwise
// [R23] No transmit or receive without DSR
// [R24] Accept received characters only with carrier
// [R25] Timeout is a parameterised cycle counter
// [R26] Static parity enable shared by both framers
package aspm_pkg;
  localparam int CLK_HZ           = 10_000_000;
  localparam int ANSWER_TIMEOUT_S = 10;
  localparam int ANSWER_TIMEOUT_CYC = ANSWER_TIMEOUT_S * CLK_HZ;
  localparam int FAULT_LIT_MS     = 500;
  localparam int FAULT_LIT_CYC    = FAULT_LIT_MS * (CLK_HZ / 1000);
  localparam int DUP_FLASH_HZ     = 1;
  localparam int DUP_HALF_CYC     = CLK_HZ / (2 * DUP_FLASH_HZ);
  localparam int ACT_BLINK_MS     = 20;
  localparam int ACT_BLINK_CYC    = ACT_BLINK_MS * (CLK_HZ / 1000);
  localparam int BAUD_RATE        = 9600;
  localparam int OVERSAMPLE       = 16;
  localparam int BAUD_DIV_DEF     = CLK_HZ / (BAUD_RATE * OVERSAMPLE);

  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] END_TICK = 4'hF;
  localparam logic [3:0] BITS_PAR = 4'hA;
  localparam logic [3:0] BITS_NOP = 4'h9;
  localparam logic [7:0] DLE_CHAR = 8'h10;
  localparam logic [7:0] NAK_CHAR = 8'h15;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TXD  = 8'h08;
  localparam logic [7:0] REG_RXD  = 8'h0C;

  localparam int CTRL_W        = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam int CTRL_PARITY   = 0;
  localparam int CTRL_HALFDUP  = 1;
  localparam int CTRL_PERMIT   = 2;
  localparam int CTRL_MASTER   = 3;
  localparam int CTRL_SENDING  = 4;
  localparam int CTRL_RECEIVING = 5;
  localparam int CTRL_POLLING  = 6;
  localparam int CTRL_PENDING  = 7;
  localparam int CTRL_DUPLICATE = 8;
  localparam int CTRL_HWFAULT  = 9;

  localparam int STAT_W = 10;

  // Sync order {dcd, dsr, cts, rxd}; line idles high
  localparam logic [3:0] SYNC_RESET = 4'h1;

  typedef enum logic [2:0] {
    MDM_WAIT_CALL,
    MDM_ANSWER,
    MDM_CONNECTED,
    MDM_CARRIER_LOST,
    MDM_HANGUP
  } aspm_modem_e;
endpackage

// file: aspm_port.sv
/*
  Asynchronous port: modem answer handshake, character framing, register
  bank on classic Wishbone and front-panel indicator drive.
  Assumes a 10 MHz clock and modem lines arriving unsynchronised.
*/
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module aspm_port
  import aspm_pkg::*;
#(
  parameter int TIMEOUT_CYC  = ANSWER_TIMEOUT_CYC,
  parameter int FAULT_CYC    = FAULT_LIT_CYC,
  parameter int DUP_HALF     = DUP_HALF_CYC,
  parameter int BLINK_CYC    = ACT_BLINK_CYC,
  parameter int BAUD_DIV     = BAUD_DIV_DEF
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  input  wire logic        cts_i,
  input  wire logic        dsr_i,
  input  wire logic        dcd_i,
  output logic             txd_o,
  output logic             rts_o,
  output logic             dtr_o,
  output logic             power_indicator_o,
  output logic             net_transmit_indicator_o,
  output logic             net_receive_indicator_o,
  output logic             pending_message_indicator_o,
  output logic             link_activity_indicator_o,
  output logic             fault_indicator_o
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int FW = $clog2(FAULT_CYC + 1);
  localparam int DW = $clog2(DUP_HALF + 1);
  localparam int BW = $clog2(BLINK_CYC + 1);
  localparam int VW = $clog2(BAUD_DIV + 1);

  if (TIMEOUT_CYC < 2 || FAULT_CYC < 2 || DUP_HALF < 2 || BLINK_CYC < 2 || BAUD_DIV < 2) begin : g_bad
    $error("aspm_port: counts must be at least 2");
  end

  function automatic logic is_nak(input logic prev_dle, input logic [7:0] ch);
    is_nak = prev_dle && (ch == NAK_CHAR);
  endfunction

  // Input synchronisers
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] filt_reg;
  logic       rxd_s;
  logic       cts_s;
  logic       dsr_s;
  logic       dcd_s;

  // Bit-rate divider
  logic [VW-1:0] div_reg;
  logic          tick_reg;

  // Registers and data path
  logic [CTRL_W-1:0] ctrl_reg;
  logic [STAT_W-1:0] stat_w;
  logic              req;
  logic              wr_req;
  logic              rd_req;
  logic [7:0]        txq_reg;
  logic              txq_full_reg;
  logic              tx_start;
  logic              tx_busy;
  logic              tx_ok;
  logic              rx_ok;
  logic              rx_valid;
  logic              rx_perr;
  logic [7:0]        rx_data;
  logic              rx_take;
  logic [7:0]        rxh_reg;
  logic              rx_full_reg;
  logic              perr_reg;
  logic              ovr_reg;
  logic              tx_dle_reg;
  logic              rx_dle_reg;
  logic              nak_ev;

  // Modem handshake
  aspm_modem_e       mdm_reg;
  aspm_modem_e       mdm_next;
  logic [TW-1:0]     tmo_reg;
  logic              tmo_load;
  logic              tmo_done;

  // Indicators
  logic [FW-1:0]     fault_cnt_reg;
  logic [DW-1:0]     dup_cnt_reg;
  logic              dup_phase_reg;
  logic [BW-1:0]     blink_cnt_reg;

  assign rxd_s = filt_reg[0];
  assign cts_s = filt_reg[1];
  assign dsr_s = filt_reg[2];
  assign dcd_s = filt_reg[3];

  // [R2] No ring input; calls sensed by DSR
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_reg   <= SYNC_RESET;
      s2_reg   <= SYNC_RESET;
      s3_reg   <= SYNC_RESET;
      filt_reg <= SYNC_RESET;
    end else begin
      s1_reg   <= {dcd_i, dsr_i, cts_i, rxd_i};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == VW'(BAUD_DIV - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + VW'(1);
      tick_reg <= 1'b0;
    end
  end

  // Wishbone slave, answers one cycle after the request
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = req && wb_we_i;
  assign rd_req = req && !wb_we_i;

  assign stat_w = {ovr_reg, perr_reg, rx_full_reg, tx_busy, txq_full_reg,
                   mdm_reg == MDM_CONNECTED, cts_s, dcd_s, dsr_s, dtr_o};

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd_req) begin
        case (wb_adr_i & 8'hFC)
          REG_CTRL: wb_dat_o <= {{(32 - CTRL_W){1'b0}}, ctrl_reg};
          REG_STAT: wb_dat_o <= {{(32 - STAT_W){1'b0}}, stat_w};
          REG_RXD:  wb_dat_o <= {24'h00_0000, rxh_reg};
          default:  wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // [R26] Parity select is software set, static
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_req && (wb_adr_i & 8'hFC) == REG_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_reg[CTRL_W-1:8] <= wb_dat_i[CTRL_W-1:8];
      end
    end
  end

  // [R23] [R22] Transmit needs DSR and CTS
  // Full duplex also waits for carrier
  assign tx_ok = dsr_s && cts_s && (ctrl_reg[CTRL_HALFDUP] || dcd_s);
  // [R23] [R24] Receive needs DSR and carrier
  assign rx_ok = dsr_s && dcd_s;
  assign tx_start = txq_full_reg && !tx_busy && tx_ok;
  assign rx_take  = rx_valid && rx_ok;

  // One-byte holding slot; writes to a full slot are dropped
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      txq_reg      <= 8'h00;
      txq_full_reg <= 1'b0;
    end else if (wr_req && (wb_adr_i & 8'hFC) == REG_TXD && wb_sel_i[0] && !txq_full_reg) begin
      txq_reg      <= wb_dat_i[7:0];
      txq_full_reg <= 1'b1;
    end else if (tx_start) begin
      txq_full_reg <= 1'b0;
    end
  end

  aspm_uart_tx u_tx (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .tick_i      (tick_reg),
    .run_i       (cts_s && dsr_s),
    .parity_en_i (ctrl_reg[CTRL_PARITY]),
    .start_i     (tx_start),
    .data_i      (txq_reg),
    .busy_o      (tx_busy),
    .txd_o       (txd_o)
  );

  aspm_uart_rx u_rx (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .tick_i      (tick_reg),
    .rxd_i       (rxd_s),
    .parity_en_i (ctrl_reg[CTRL_PARITY]),
    .valid_o     (rx_valid),
    .perr_o      (rx_perr),
    .data_o      (rx_data)
  );

  // Set wins over the clear by an RXD read
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rxh_reg     <= 8'h00;
      rx_full_reg <= 1'b0;
      perr_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
    end else if (rx_take) begin
      rxh_reg     <= rx_data;
      rx_full_reg <= 1'b1;
      perr_reg    <= perr_reg || rx_perr;
      ovr_reg     <= ovr_reg || rx_full_reg;
    end else if (rd_req && (wb_adr_i & 8'hFC) == REG_RXD) begin
      rx_full_reg <= 1'b0;
      perr_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
    end
  end

  // [R19] Escape-NAK pairs in either direction
  assign nak_ev = (tx_start && is_nak(tx_dle_reg, txq_reg)) ||
                  (rx_take && is_nak(rx_dle_reg, rx_data));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_dle_reg <= 1'b0;
      rx_dle_reg <= 1'b0;
    end else begin
      if (tx_start) begin
        tx_dle_reg <= (txq_reg == DLE_CHAR) && !tx_dle_reg;
      end
      if (rx_take) begin
        rx_dle_reg <= (rx_data == DLE_CHAR) && !rx_dle_reg;
      end
    end
  end

  // Answer and carrier supervision
  always_comb begin
    mdm_next = mdm_reg;
    tmo_load = 1'b0;
    case (mdm_reg)
      MDM_WAIT_CALL: begin
        // [R3] DSR starts the carrier wait
        if (dsr_s) begin
          mdm_next = MDM_ANSWER;
          tmo_load = 1'b1;
        end
      end
      MDM_ANSWER: begin
        if (!dsr_s) begin
          mdm_next = MDM_WAIT_CALL;
        // [R4] Carrier in time connects
        end else if (dcd_s) begin
          mdm_next = MDM_CONNECTED;
        // [R5] No carrier, force hang-up
        end else if (tmo_done) begin
          mdm_next = MDM_HANGUP;
        end
      end
      MDM_CONNECTED: begin
        if (!dsr_s) begin
          mdm_next = MDM_WAIT_CALL;
        // [R7] Carrier loss restarts timeout
        end else if (!dcd_s) begin
          mdm_next = MDM_CARRIER_LOST;
          tmo_load = 1'b1;
        end
      end
      MDM_CARRIER_LOST: begin
        if (!dsr_s) begin
          mdm_next = MDM_WAIT_CALL;
        end else if (dcd_s) begin
          mdm_next = MDM_CONNECTED;
        // [R8] Still lost, begin hang-up
        end else if (tmo_done) begin
          mdm_next = MDM_HANGUP;
        end
      end
      MDM_HANGUP: begin
        // [R6] DSR off, wait for next call
        if (!dsr_s) begin
          mdm_next = MDM_WAIT_CALL;
        end
      end
      default: mdm_next = MDM_WAIT_CALL;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mdm_reg <= MDM_WAIT_CALL;
      dtr_o   <= 1'b0;
    end else begin
      mdm_reg <= mdm_next;
      // [R1] [R5] [R8] DTR off only in hang-up
      dtr_o   <= (mdm_next != MDM_HANGUP);
    end
  end

  // [R25] Down-counter, length is a parameter
  assign tmo_done = (tmo_reg == '0);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tmo_reg <= '0;
    end else if (tmo_load) begin
      tmo_reg <= TW'(TIMEOUT_CYC - 1);
    end else if (!tmo_done) begin
      tmo_reg <= tmo_reg - TW'(1);
    end
  end

  // [R21] RTS from duplex mode and permit
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rts_o <= 1'b0;
    end else begin
      rts_o <= !ctrl_reg[CTRL_HALFDUP] || ctrl_reg[CTRL_PERMIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fault_cnt_reg <= '0;
    end else if (nak_ev) begin
      fault_cnt_reg <= FW'(FAULT_CYC);
    end else if (fault_cnt_reg != '0) begin
      fault_cnt_reg <= fault_cnt_reg - FW'(1);
    end
  end

  // Half-period toggle gives the slow flash
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !ctrl_reg[CTRL_DUPLICATE]) begin
      dup_cnt_reg   <= '0;
      dup_phase_reg <= 1'b0;
    end else if (dup_cnt_reg == DW'(DUP_HALF - 1)) begin
      dup_cnt_reg   <= '0;
      dup_phase_reg <= !dup_phase_reg;
    end else begin
      dup_cnt_reg   <= dup_cnt_reg + DW'(1);
    end
  end

  // Retriggered per character so busy traffic looks like flicker
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      blink_cnt_reg <= '0;
    end else if (tx_start || rx_take) begin
      blink_cnt_reg <= BW'(BLINK_CYC);
    end else if (blink_cnt_reg != '0) begin
      blink_cnt_reg <= blink_cnt_reg - BW'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      power_indicator_o           <= 1'b0;
      net_transmit_indicator_o    <= 1'b0;
      net_receive_indicator_o     <= 1'b0;
      pending_message_indicator_o <= 1'b0;
      link_activity_indicator_o   <= 1'b0;
      fault_indicator_o           <= 1'b0;
    end else begin
      power_indicator_o <= 1'b1;
      // [R14] [R16] Transmit light
      net_transmit_indicator_o <= (ctrl_reg[CTRL_MASTER] && ctrl_reg[CTRL_SENDING]) ||
                                  (ctrl_reg[CTRL_MASTER] && ctrl_reg[CTRL_POLLING]);
      // [R15] [R16] Receive light
      net_receive_indicator_o <= ctrl_reg[CTRL_RECEIVING] ||
                                 (ctrl_reg[CTRL_MASTER] && ctrl_reg[CTRL_POLLING]);
      // [R17] Waiting for mastership
      pending_message_indicator_o <= ctrl_reg[CTRL_PENDING] && !ctrl_reg[CTRL_MASTER];
      // [R18] DSR shows cable, blink per character
      link_activity_indicator_o <= dsr_s && (blink_cnt_reg == '0);
      // [R19] [R20] Steady fault beats flash
      fault_indicator_o <= ctrl_reg[CTRL_HWFAULT] || (fault_cnt_reg != '0) ||
                           (ctrl_reg[CTRL_DUPLICATE] && dup_phase_reg);
    end
  end
endmodule

// file: aspm_port_bench.sv
/*
  Self-checking bench for aspm_port over classic Wishbone.
  Assumes the modem model beside it; long counts shortened by parameters.
*/
`timescale 1ns/1ps
module aspm_port_bench import aspm_pkg::*;;
  localparam int TO = 400;
  localparam int BIT = 32;
  logic clk_sys_i = 0, srst_i = 1, cyc = 0, we = 0, ring = 0, car = 0, cts_en = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dato;
  logic ack, txd, rts, dtr, dsr, dcd, cts, rxd, power_indicator, l_tx, l_rx, l_pend, l_act, l_flt;
  int n_mismatch = 0, cmp_count = 0;
  logic [9:0] lc[9] = '{10'h018, 10'h020, 10'h048, 10'h080, 10'h088, 10'h002, 10'h006, 10'h200, 10'h000};
  logic [4:0] le[9] = '{5'h18, 5'h14, 5'h1C, 5'h12, 5'h10, 5'h00, 5'h10, 5'h11, 5'h10};
  always #50 clk_sys_i = ~clk_sys_i;
  aspm_port #(.TIMEOUT_CYC(TO), .FAULT_CYC(50), .DUP_HALF(20), .BLINK_CYC(20), .BAUD_DIV(2)) DUT (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .rxd_i(rxd), .cts_i(cts),
    .dsr_i(dsr), .dcd_i(dcd), .txd_o(txd), .rts_o(rts), .dtr_o(dtr), .power_indicator_o(power_indicator),
    .net_transmit_indicator_o(l_tx), .net_receive_indicator_o(l_rx), .pending_message_indicator_o(l_pend),
    .link_activity_indicator_o(l_act), .fault_indicator_o(l_flt));
  aspm_modem #(.BIT_CYC(BIT)) MDM (.clk_sys_i(clk_sys_i), .dtr_i(dtr), .ring_i(ring), .carrier_i(car),
    .cts_en_i(cts_en), .dsr_o(dsr), .dcd_o(dcd), .cts_o(cts), .rxd_o(rxd));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      print_verdict();
    end
    rdat = dato;
    cyc <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_sig(input bit on_txd, input logic v, input int lim, output int n);
    n = 0;
    while ((on_txd ? txd : dtr) !== v) begin
      @(posedge clk_sys_i);
      n++;
      if (n > lim) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask
  // Bit time counts only while clear-to-send is given, so a pause shifts sampling
  task automatic get_frame(input int nbits, output logic [10:0] f);
    int n, c;
    wait_sig(1, 1'b0, 3000, n);
    f = '1;
    for (int i = 0; i < nbits; i++) begin
      c = 0;
      while (c < (i == 0 ? BIT / 2 : BIT)) begin
        @(posedge clk_sys_i);
        if (cts_en) c++;
      end
      f[i] = txd;
    end
  endtask
  initial begin
    int n;
    logic [10:0] f;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(dtr, 1, "dtr idle");
    check(power_indicator, 1, "power");
    wb(0, REG_CTRL, 0);
    check(rdat, 0, "ctrl reset");
    wb(1, 8'h40, 32'h3FF);
    wb(0, 8'h40, 0);
    check(rdat, 0, "unmapped");
    wb(1, REG_TXD, 8'h55);
    repeat (100) @(posedge clk_sys_i);
    check(txd, 1, "no tx offhook");
    $display("test regs done");
    foreach (lc[i]) begin
      wb(1, REG_CTRL, lc[i]);
      wb(0, REG_CTRL, 0);
      check(rdat, lc[i], "ctrl readback");
      repeat (3) @(posedge clk_sys_i);
      check({rts, l_tx, l_rx, l_pend, l_flt}, le[i], "lights");
    end
    wb(1, REG_CTRL, 10'h100);
    repeat (29) @(posedge clk_sys_i);
    check(l_flt, 1, "dup flash on");
    repeat (20) @(posedge clk_sys_i);
    check(l_flt, 0, "dup flash off");
    wb(1, REG_CTRL, 0);
    $display("test lights done");
    ring <= 1'b1;
    wait_sig(0, 1'b0, TO + 40, n);
    check(n >= TO, 1, "answer wait");
    ring <= 1'b0;
    wait_sig(0, 1'b1, 60, n);
    check(dsr, 0, "dsr after hangup");
    $display("test answer done");
    car <= 1'b1;
    ring <= 1'b1;
    get_frame(10, f);
    check(f, {2'b11, 8'h55, 1'b0}, "held byte");
    ring <= 1'b0;
    wb(0, REG_STAT, 0);
    check(rdat[4], 1, "connected");
    repeat (40) @(posedge clk_sys_i);
    check(l_act, 1, "activity");
    wb(1, REG_CTRL, 1);
    MDM.send_char(DLE_CHAR, 1);
    MDM.send_char(NAK_CHAR, 1);
    wb(0, REG_RXD, 0);
    check(rdat[7:0], NAK_CHAR, "rx byte");
    check(l_flt, 1, "fault lit");
    check(l_act, 0, "activity blink");
    repeat (60) @(posedge clk_sys_i);
    check(l_flt, 0, "fault off");
    car <= 1'b0;
    MDM.send_char(8'h41, 1);
    car <= 1'b1;
    wb(0, REG_STAT, 0);
    check(rdat[7], 0, "rx no carrier");
    $display("test receive done");
    wb(1, REG_TXD, 8'hB5);
    fork
      get_frame(11, f);
      begin
        repeat (100) @(posedge clk_sys_i);
        cts_en <= 1'b0;
        repeat (50) @(posedge clk_sys_i);
        cts_en <= 1'b1;
      end
    join
    check(f, {1'b1, ^8'hB5, 8'hB5, 1'b0}, "tx parity frame");
    $display("test transmit done");
    car <= 1'b0;
    repeat (TO - 60) @(posedge clk_sys_i);
    car <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    car <= 1'b0;
    wait_sig(0, 1'b0, TO + 40, n);
    check(n >= TO, 1, "loss restart");
    wait_sig(0, 1'b1, 60, n);
    $display("test carrier loss done");
    print_verdict();
  end
endmodule

// file: aspm_port_chk.sv
/*
  Checker for aspm_port: bus answer, modem handshake, serial line, lights.
  Assumes the timeout parameter is handed on by the bind.
*/
`timescale 1ns/1ps
module aspm_port_chk #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic txd_o,
  input wire logic dtr_o,
  input wire logic link_activity_indicator_o,
  input wire logic fault_indicator_o
);
  int unsigned lost_cnt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Off-hook cycles without carrier; saturates so it cannot wrap
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !dsr_i || dcd_i) begin
      lost_cnt <= 0;
    end else if (lost_cnt < TIMEOUT_CYC + 20) begin
      lost_cnt <= lost_cnt + 1;
    end
  end
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_follows:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  chk_dtr_idle:
    assert property (!dsr_i [*8] |-> dtr_o) else $error("dtr low while idle");
  chk_dtr_early:
    assert property ($fell(dtr_o) |-> lost_cnt >= TIMEOUT_CYC) else $error("dtr dropped early");
  chk_dtr_late:
    assert property (lost_cnt == TIMEOUT_CYC + 10 |-> !dtr_o) else $error("dtr not dropped");
  chk_dtr_back:
    assert property ($fell(dsr_i) && !dtr_o |-> ##[1:8] dtr_o) else $error("dtr not restored");
  chk_cts_pause:
    assert property (!cts_i [*6] |-> $stable(txd_o)) else $error("txd moved without cts");
  chk_tx_dsr:
    assert property (!dsr_i [*6] ##0 txd_o |=> txd_o) else $error("tx started without dsr");
  chk_act_dsr:
    assert property (!dsr_i [*6] |-> !link_activity_indicator_o) else $error("activity lit unplugged");
  chk_fault_hold:
    assert property ($rose(fault_indicator_o) |=> fault_indicator_o [*8]) else $error("fault flash short");
  cover property ($fell(dtr_o));
  cover property ($rose(fault_indicator_o));
  cover property (!cts_i && !txd_o);
endmodule
bind aspm_port aspm_port_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.*);

// file: aspm_uart_rx.sv
/*
  Serial character receiver with optional even parity check.
  Assumes a synchronised line and a 16x bit-rate enable pulse.
*/
`timescale 1ns/1ps
module aspm_uart_rx
  import aspm_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       tick_i,
  input  wire logic       rxd_i,
  input  wire logic       parity_en_i,
  output logic            valid_o,
  output logic            perr_o,
  output logic [7:0]      data_o
);
  logic       active_reg;
  logic       par_reg;
  logic [3:0] bits_reg;
  logic [3:0] sub_reg;
  logic [7:0] shift_reg;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      active_reg <= 1'b0;
      par_reg    <= 1'b0;
      bits_reg   <= 4'h0;
      sub_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      valid_o    <= 1'b0;
      perr_o     <= 1'b0;
      data_o     <= 8'h00;
    end else begin
      valid_o <= 1'b0;
      if (tick_i && !active_reg && !rxd_i) begin
        active_reg <= 1'b1;
        bits_reg   <= 4'h0;
        sub_reg    <= 4'h0;
      end else if (tick_i && active_reg) begin
        sub_reg <= sub_reg + 4'h1;
        if (sub_reg == MID_TICK) begin
          bits_reg <= bits_reg + 4'h1;
          // [R12] [R13] Start, data, parity, stop
          if (bits_reg == 4'h0) begin
            active_reg <= !rxd_i;
          end else if (bits_reg <= 4'h8) begin
            shift_reg <= {rxd_i, shift_reg[7:1]};
          end else if (parity_en_i && bits_reg == BITS_NOP) begin
            par_reg <= rxd_i;
          end else begin
            // Framing error drops the character
            active_reg <= 1'b0;
            valid_o    <= rxd_i;
            data_o     <= shift_reg;
            perr_o     <= parity_en_i && ((^shift_reg) != par_reg);
          end
        end
      end
    end
  end
endmodule

// file: aspm_uart_tx.sv
/*
  Serial character transmitter with optional even parity.
  Assumes a 16x bit-rate enable pulse and a run level from the parent.
*/
`timescale 1ns/1ps
module aspm_uart_tx
  import aspm_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic       parity_en_i,
  input  wire logic       start_i,
  input  wire logic [7:0] data_i,
  output logic            busy_o,
  output logic            txd_o
);
  logic [9:0] shift_reg;
  logic [3:0] bits_reg;
  logic [3:0] sub_reg;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      busy_o    <= 1'b0;
      txd_o     <= 1'b1;
      shift_reg <= 10'h3FF;
      bits_reg  <= 4'h0;
      sub_reg   <= 4'h0;
    end else if (!busy_o) begin
      if (start_i) begin
        // [R12] [R13] LSB first, parity, one stop
        busy_o    <= 1'b1;
        txd_o     <= 1'b0;
        shift_reg <= {1'b1, parity_en_i ? ^data_i : 1'b1, data_i};
        bits_reg  <= parity_en_i ? BITS_PAR : BITS_NOP;
        sub_reg   <= 4'h0;
      end
    // [R22] Stalls mid-bit while CTS is off
    end else if (tick_i && run_i) begin
      sub_reg <= sub_reg + 4'h1;
      if (sub_reg == END_TICK) begin
        if (bits_reg == 4'h0) begin
          busy_o <= 1'b0;
        end else begin
          txd_o     <= shift_reg[0];
          shift_reg <= {1'b1, shift_reg[9:1]};
          bits_reg  <= bits_reg - 4'h1;
        end
      end
    end
  end
endmodule
